/* shared/sfo_pkg.sv */
// Constants for the serial flash OTP access block.
// Assumes a 10 MHz system clock and an APB register port.
package sfo_pkg;
  // Instruction opcodes
  localparam logic [7:0] OP_WEN = 8'h06;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_OTP_RD = 8'h4B;
  // OTP address space
  localparam logic [11:0] OTP_FIRST = 12'h100;
  localparam logic [11:0] OTP_LAST = 12'h215;
  localparam int OTP_DEPTH = 278;
  localparam logic [11:0] ESN_LOCK = 12'h100;
  localparam logic [11:0] SN_LOW_FIRST = 12'h102;
  localparam logic [11:0] SN_LOW_LAST = 12'h109;
  localparam logic [11:0] SN_HIGH_FIRST = 12'h10A;
  localparam logic [11:0] SN_HIGH_LAST = 12'h111;
  localparam logic [11:0] REGION_LOCK_LO = 12'h112;
  localparam logic [11:0] REGION_LOCK_HI = 12'h113;
  localparam logic [11:0] REGION_FIRST = 12'h114;
  localparam logic [11:0] REGION_LAST = 12'h213;
  localparam logic [11:0] TOP_LOCK = 12'h215;
  localparam logic [11:0] IDX_ESN_LOCK_W = ESN_LOCK - OTP_FIRST;
  localparam logic [11:0] IDX_REG_LO_W = REGION_LOCK_LO - OTP_FIRST;
  localparam logic [11:0] IDX_REG_HI_W = REGION_LOCK_HI - OTP_FIRST;
  localparam logic [11:0] IDX_TOP_W = TOP_LOCK - OTP_FIRST;
  localparam logic [8:0] IDX_ESN_LOCK = IDX_ESN_LOCK_W[8:0];
  localparam logic [8:0] IDX_REG_LO = IDX_REG_LO_W[8:0];
  localparam logic [8:0] IDX_REG_HI = IDX_REG_HI_W[8:0];
  localparam logic [8:0] IDX_TOP = IDX_TOP_W[8:0];
  localparam int SN_LOW_LOCK_BIT = 0;
  localparam int SN_HIGH_LOCK_BIT = 1;
  localparam logic [7:0] ESN_LOCK_FIXED = 8'hFC;
  localparam logic [7:0] TOP_LOCK_FIXED = 8'h80;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] STATUS_INIT = 8'h00;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int POWER_UP_DELAY_US = 300;
  localparam int POWER_UP_CYCLES = POWER_UP_DELAY_US * (CLK_HZ / 1_000_000);
  // APB register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PEEK_ADDR = 8'h08;
  localparam logic [7:0] REG_PEEK_DATA = 8'h0C;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_QUAD_BIT = 1;
  // Frame decoder states
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_STAT = 3'b101,
    ST_WEN = 3'b110,
    ST_IGNORE = 3'b111
  } sfo_state_t;
endpackage : sfo_pkg

/* logic/sfo_sync.sv */
// Two-flop synchroniser with edge detection for link pins.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module sfo_sync import sfo_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  if (W < 1) begin : g_bad_w
    $error("sfo_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sfo_sync_t;

  sfo_sync_t st;
  sfo_sync_t next_st;

  // Shift the chain; only s2 and s3 are looked at
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= {RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  // Edges per bit
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign lvl[i] = st.s2[i];
    assign rise[i] = st.s2[i] & ~st.s3[i];
    assign fall[i] = ~st.s2[i] & st.s3[i];
  end
endmodule : sfo_sync

/* logic/sfo_otp_access.sv */
// OTP access slice of a serial NOR flash: serial frame decoder, OTP store,
// lock bits, accel pin gating, and an APB port for control and inspection.
// Assumes clk at 10 MHz and a link clock far slower than clk.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sfo_otp_access import sfo_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic accel_hv,
  output logic so_out,
  output logic so_oe
);
  if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES > 4096) begin : g_bad_pu
    $error("sfo_otp_access: power-up count out of range");
  end

  typedef struct packed {
    sfo_state_t state;
    logic [7:0] op;
    logic [7:0] shin;
    logic [2:0] bitc;
    logic [1:0] bytec;
    logic [23:0] addr;
    logic [1:0] dcnt;
    logic [7:0] data;
    logic lock_hit;
    logic [7:0] shout;
    logic load;
    logic frame;
    logic write_enable_latch;
    logic otp_space;
    logic [11:0] pu_cnt;
    logic ready;
    logic busy;
    logic quad;
    logic [8:0] peek;
    logic [31:0] prdata;
  } sfo_core_t;

  sfo_core_t st;
  sfo_core_t next_st;
  logic [7:0] mem [OTP_DEPTH];

  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic si_lvl;
  logic accel_eff;
  logic [7:0] byte_in;
  logic [23:0] addr_next;
  logic [7:0] rd_byte;
  logic [7:0] peek_byte;
  logic [7:0] dev_status;
  logic [7:0] lock_esn;
  logic [15:0] lock_reg;
  logic [11:0] rel;
  logic lock_new;
  logic prog_we;
  logic [8:0] prog_idx;
  logic [7:0] prog_val;
  logic [7:0] old_byte;
  logic [7:0] fixed_mask;
  logic [31:0] rd_word;
  logic mapped;

  function automatic logic in_span(input logic [23:0] a, input logic [11:0] lo,
                                   input logic [11:0] hi);
    return (a >= {12'h000, lo}) && (a <= {12'h000, hi});
  endfunction : in_span

  function automatic logic [8:0] idx_of(input logic [23:0] a);
    logic [23:0] d;
    d = a - {12'h000, OTP_FIRST};
    return d[8:0];
  endfunction : idx_of

  // Pin synchronisers: bit 0 cs_n, 1 sck, 2 si, 3 accel
  sfo_sync #(.W(4), .RST_VAL(4'h1)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({accel_hv, si, sck, cs_n}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_rise = pin_rise[0];
  assign cs_fall = pin_fall[0];
  assign sck_rise = pin_rise[1] & ~pin_lvl[0];
  assign sck_fall = pin_fall[1] & ~pin_lvl[0];
  assign si_lvl = pin_lvl[2];
  // Shared pin is only data in quad mode
  assign accel_eff = pin_lvl[3] & ~st.quad;

  // Byte being completed and the address it would form
  assign byte_in = {st.shin[6:0], si_lvl};
  assign addr_next = {st.addr[15:0], byte_in};
  assign dev_status = {6'h00, st.write_enable_latch, st.busy};

  // Read paths; a link read outside the OTP space returns ERASED (8'hFF)
  assign rd_byte = in_span(st.addr, OTP_FIRST, OTP_LAST) ? mem[prog_idx] : ERASED;
  assign peek_byte = (st.peek < 9'(OTP_DEPTH)) ? mem[st.peek] : 8'h00;

  // Lock bytes; a programmed (0) bit locks its region
  assign lock_esn = mem[IDX_ESN_LOCK];
  assign lock_reg = {mem[IDX_REG_HI], mem[IDX_REG_LO]};

  // Lock lookup for the address now being completed
  always_comb begin
    rel = addr_next[11:0] - REGION_FIRST;
    lock_new = 1'b0;
    if (in_span(addr_next, SN_LOW_FIRST, SN_LOW_LAST)) begin
      lock_new = ~lock_esn[SN_LOW_LOCK_BIT];
    end else if (in_span(addr_next, SN_HIGH_FIRST, SN_HIGH_LAST)) begin
      lock_new = ~lock_esn[SN_HIGH_LOCK_BIT];
    end else if (in_span(addr_next, REGION_FIRST, REGION_LAST)) begin
      lock_new = ~lock_reg[rel[7:4]];
    end
  end

  // Program value: bits can only be cleared, fixed lock bits never move
  always_comb begin
    prog_idx = idx_of(st.addr);
    old_byte = mem[prog_idx];
    fixed_mask = 8'h00;
    if (prog_idx == IDX_ESN_LOCK) begin
      fixed_mask = ESN_LOCK_FIXED;
    end else if (prog_idx == IDX_TOP) begin
      fixed_mask = TOP_LOCK_FIXED;
    end
    prog_val = old_byte & (st.data | fixed_mask);
  end

  // APB read mux
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_word = {30'h0, st.quad, st.busy};
      REG_STATUS: rd_word = {27'h0, accel_eff, st.ready, st.otp_space, st.frame, dev_status[1]};
      REG_PEEK_ADDR: rd_word = {23'h0, st.peek};
      REG_PEEK_DATA: rd_word = {24'h0, peek_byte};
      default: mapped = 1'b0;
    endcase
  end

  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st.prdata;
  assign so_out = st.shout[7];
  assign so_oe = st.frame & ((st.state == ST_READ) | (st.state == ST_STAT));

  // Main next-state logic
  always_comb begin
    next_st = st;
    prog_we = 1'b0;
    // Power-up delay; frames before it ends are dropped
    if (!st.ready) begin
      if (st.pu_cnt == 12'(POWER_UP_CYCLES - 1)) begin
        next_st.ready = 1'b1;
      end else begin
        next_st.pu_cnt = st.pu_cnt + 12'd1;
      end
    end
    // APB: capture read data in setup, apply writes in access
    if (psel && !penable) begin
      next_st.prdata = rd_word;
    end
    if (psel && penable && pwrite) begin
      if (paddr == REG_CTRL) begin
        next_st.busy = pwdata[CTRL_BUSY_BIT];
        next_st.quad = pwdata[CTRL_QUAD_BIT];
      end else if (paddr == REG_PEEK_ADDR) begin
        next_st.peek = pwdata[8:0];
      end
    end
    // Link frames
    if (cs_fall) begin
      next_st.frame = 1'b1;
      next_st.state = st.ready ? ST_CMD : ST_IGNORE;
      next_st.bitc = 3'd0;
      next_st.bytec = 2'd0;
      next_st.dcnt = 2'd0;
      next_st.load = 1'b0;
      next_st.shout = ERASED;
    end else if (cs_rise) begin
      if (st.frame && st.state == ST_DATA) begin
        // Commit only a whole single byte with the latch set
        if (st.dcnt == 2'd1 && st.bitc == 3'd0 && !st.lock_hit
            && st.write_enable_latch && !st.busy
            && in_span(st.addr, OTP_FIRST, OTP_LAST)) begin
          prog_we = 1'b1;
        end
        next_st.write_enable_latch = 1'b0;
      end
      if (st.frame && st.state == ST_WEN && st.bitc == 3'd0) begin
        next_st.write_enable_latch = 1'b1;
      end
      next_st.frame = 1'b0;
      next_st.state = ST_CMD;
      next_st.otp_space = 1'b0;
      next_st.load = 1'b0;
    end else if (st.frame && sck_rise) begin
      next_st.shin = byte_in;
      next_st.bitc = st.bitc + 3'd1;
      if (st.bitc == 3'd7) begin
        case (st.state)
          ST_CMD: begin
            next_st.op = byte_in;
            next_st.bytec = 2'd0;
            next_st.addr = 24'h000000;
            if (accel_eff && byte_in != OP_STAT_RD && byte_in != OP_PP) begin
              next_st.state = ST_IGNORE;
            end else if (byte_in == OP_OTP_PROG || byte_in == OP_OTP_RD) begin
              next_st.state = st.busy ? ST_IGNORE : ST_ADDR;
              next_st.otp_space = ~st.busy;
            end else if (byte_in == OP_STAT_RD) begin
              next_st.state = ST_STAT;
              next_st.load = 1'b1;
            end else if (byte_in == OP_WEN) begin
              next_st.state = ST_WEN;
            end else begin
              // Erase and other opcodes never reach the OTP store
              next_st.state = ST_IGNORE;
            end
          end
          ST_ADDR: begin
            next_st.addr = addr_next;
            next_st.bytec = st.bytec + 2'd1;
            if (st.bytec == 2'd2) begin
              if (st.op == OP_OTP_PROG) begin
                next_st.state = ST_DATA;
                next_st.lock_hit = lock_new;
              end else begin
                next_st.state = ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            next_st.state = ST_READ;
            next_st.load = 1'b1;
          end
          ST_DATA: begin
            next_st.data = byte_in;
            next_st.dcnt = (st.dcnt == 2'd2) ? 2'd2 : st.dcnt + 2'd1;
          end
          ST_READ: begin
            // No wrap at the top: the address runs on past the space
            next_st.addr = st.addr + 24'd1;
            next_st.load = 1'b1;
          end
          ST_STAT: next_st.load = 1'b1;
          ST_WEN: next_st.state = ST_IGNORE;
          default: next_st.state = ST_IGNORE;
        endcase
      end
    end else if (st.frame && sck_fall) begin
      // Output shifts on the falling edge, MSB first
      if (st.load) begin
        next_st.shout = (st.state == ST_STAT) ? dev_status : rd_byte;
        next_st.load = 1'b0;
      end else begin
        next_st.shout = {st.shout[6:0], 1'b1};
      end
    end
  end

  // State register; reset gives standby with the latch clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.state <= ST_CMD;
      st.shout <= ERASED;
      st.op <= STATUS_INIT;
    end else begin
      st <= next_st;
    end
  end

  // OTP store; reset gives the erased delivery state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < OTP_DEPTH; i++) begin
        mem[i] <= ERASED;
      end
    end else if (prog_we) begin
      mem[prog_idx] <= prog_val;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_frame_end;
    st.frame && cs_rise;
  endsequence

  sequence s_back_normal;
    !st.otp_space && !st.frame;
  endsequence

  property p_space_return;
    s_frame_end |=> s_back_normal;
  endproperty

  chk_only_clears: assert property (prog_we |-> ((prog_val & ~old_byte) == 8'h00))
    else $error("OTP program set a bit");
  chk_lock_refuses: assert property (prog_we
      |-> (!st.lock_hit && st.write_enable_latch))
    else $error("Program committed to a locked region or without latch");
  chk_range_only: assert property (prog_we |-> in_span(st.addr, OTP_FIRST, OTP_LAST))
    else $error("Program committed outside OTP space");
  chk_one_byte: assert property (prog_we |-> (st.dcnt == 2'd1 && st.bitc == 3'd0))
    else $error("Program committed without exactly one byte");
  chk_esn_fixed: assert property ((prog_we && prog_idx == IDX_ESN_LOCK)
      |-> (prog_val[7:2] == old_byte[7:2]))
    else $error("Fixed bits of serial lock byte changed");
  chk_top_fixed: assert property ((prog_we && prog_idx == IDX_TOP)
      |-> (prog_val[7] == old_byte[7]))
    else $error("Fixed bit of top lock byte changed");
  chk_space_end: assert property (p_space_return)
    else $error("OTP space or frame held after frame end");
  chk_busy_refuse: assert property ($rose(st.otp_space) |-> !$past(st.busy))
    else $error("OTP space entered during embedded operation");
  chk_accel_gate: assert property ($rose(st.otp_space) |-> !$past(accel_eff))
    else $error("OTP access started under high voltage");
  chk_early_frame: assert property (($rose(st.frame) && !st.ready)
      |-> (st.state == ST_IGNORE))
    else $error("Frame decoded before power-up delay");
  chk_latch_drop: assert property (prog_we |=> !st.write_enable_latch [*2])
    else $error("Latch survived an OTP program");
endmodule : sfo_otp_access

/* tb/sfo_host.sv */
// Host serial controller model that drives frames into the OTP access block.
// Assumes the 100 ns bench clock; the 800 ns link clock is built from it.
`timescale 1ns/1ps
module sfo_host import sfo_pkg::*; (
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si
);
  logic last;
  // Idle pins: deselected, link clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    last = 1'b1;
  end
  // Half of the link clock period
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half
  // One frame in mode 0, MSB first; a released output reads as the inverse of its last bit
  task automatic frame(input logic [7:0] tx[$],
                       output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    r = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        si <= tx[i][b];
        half();
        sck <= 1'b1;
        last = so_oe ? so_out : ~last;
        r = {r[6:0], last};
        half();
        sck <= 1'b0;
      end
      rx.push_back(r);
    end
    half();
    cs_n <= 1'b1;
    si <= ~tx[tx.size()-1][0];
    repeat (8) @(posedge clk);
  endtask : frame
  // Write enable first, then the one-byte program frame
  task automatic otp_prog(input logic [23:0] a, input logic [7:0] d);
    logic [7:0] rx[$];
    frame('{OP_WEN}, rx);
    frame('{OP_OTP_PROG, a[23:16], a[15:8], a[7:0], d}, rx);
  endtask : otp_prog
endmodule : sfo_host

/* tb/sfo_otp_access_bench.sv */
// Self-checking bench for the OTP access block: APB tasks plus host frames.
// Assumes sfo_host as the serial partner and the package constants.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module sfo_otp_access_bench import sfo_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic accel_hv = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cs_n, sck, si, so_out, so_oe;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] rx[$];
  always #50 clk = ~clk;
  sfo_otp_access uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .si(si), .accel_hv(accel_hv),
    .so_out(so_out), .so_oe(so_oe));
  sfo_host host (.clk(clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Inspect one OTP byte through the peek window
  task automatic peek(input logic [11:0] a, input logic [7:0] e);
    logic [11:0] i;
    i = a - OTP_FIRST;
    apb(1'b1, REG_PEEK_ADDR, {23'h0, i[8:0]});
    apb(1'b0, REG_PEEK_DATA, 32'h0);
    `CHK(rd[7:0], e)
  endtask : peek
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Watchdog against a hung handshake or frame
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd[7:0], STATUS_INIT)
    peek(12'h215, ERASED);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(err, 1'b1)
    host.frame('{OP_WEN}, rx);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    while (rd[3] !== 1'b1) apb(1'b0, REG_STATUS, 32'h0);
    host.frame('{OP_OTP_PROG, 8'h00, 8'h01, 8'h50, 8'h0F}, rx);
    peek(12'h150, ERASED);
    host.otp_prog(24'h000150, 8'hF0);
    peek(12'h150, 8'hF0);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'b000)
    host.otp_prog(24'h000150, 8'h3C);
    peek(12'h150, 8'h30);
    host.frame('{OP_WEN}, rx);
    host.frame('{8'hC7}, rx);
    peek(12'h150, 8'h30);
    host.frame('{OP_OTP_RD, 8'h00, 8'h01, 8'h4F, 8'h00, 8'h00, 8'h00}, rx);
    `CHK(rx[5], ERASED)
    `CHK(rx[6], 8'h30)
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[2], 1'b0)
    host.otp_prog(24'h010150, 8'h00);
    host.otp_prog(24'h000216, 8'h00);
    host.otp_prog(24'h0000FF, 8'h00);
    peek(12'h150, 8'h30);
    peek(12'h215, ERASED);
    peek(12'h100, ERASED);
    host.frame('{OP_WEN}, rx);
    host.frame('{OP_OTP_PROG, 8'h00, 8'h01, 8'h50, 8'h00, 8'h00}, rx);
    host.frame('{OP_WEN}, rx);
    host.frame('{OP_OTP_PROG, 8'h00, 8'h01, 8'h50}, rx);
    peek(12'h150, 8'h30);
    host.otp_prog(24'h000100, 8'hFE);
    host.otp_prog(24'h000102, 8'h00);
    peek(12'h102, ERASED);
    host.otp_prog(24'h00010A, 8'h55);
    peek(12'h10A, 8'h55);
    host.otp_prog(24'h000100, 8'h01);
    peek(12'h100, ESN_LOCK_FIXED);
    host.otp_prog(24'h00010B, 8'h00);
    peek(12'h10B, ERASED);
    host.otp_prog(24'h000215, 8'h00);
    peek(12'h215, TOP_LOCK_FIXED);
    host.otp_prog(24'h000112, 8'hFE);
    host.otp_prog(24'h000114, 8'h00);
    peek(12'h114, ERASED);
    host.otp_prog(24'h000124, 8'h00);
    peek(12'h124, 8'h00);
    apb(1'b1, REG_CTRL, 32'h1);
    host.otp_prog(24'h000130, 8'h00);
    peek(12'h130, ERASED);
    apb(1'b1, REG_CTRL, 32'h0);
    // The refused frame left the latch set; this program uses and clears it
    host.otp_prog(24'h000130, 8'h00);
    peek(12'h130, 8'h00);
    accel_hv <= 1'b1;
    repeat (50) @(posedge clk);
    host.frame('{OP_WEN}, rx);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    `CHK(rd[4], 1'b1)
    host.frame('{OP_STAT_RD, 8'h00}, rx);
    `CHK(rx[1], 8'h00)
    apb(1'b1, REG_CTRL, 32'h2);
    host.frame('{OP_WEN}, rx);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    `CHK(rd[4], 1'b0)
    host.frame('{OP_STAT_RD, 8'h00}, rx);
    `CHK(rx[1], 8'h02)
    apb(1'b1, REG_CTRL, 32'h0);
    accel_hv <= 1'b0;
    repeat (50) @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    final_report();
  end
endmodule : sfo_otp_access_bench
